// ### hdl/pbm_pin_cell.sv
// One port B pin: chooses between general-purpose, address and clock drive.
// Assumes all inputs come from the same clock domain; the caller registers the result.
`default_nettype none

module pbm_pin_cell #(
    parameter bit HAS_CLK = 1'b0                       // Pin can carry a clock monitor
) (
    input  wire logic               gpio_en_i,         // General-purpose control active
    input  wire logic               dir_out_i,         // Output direction in general-purpose mode
    input  wire logic               data_i,            // Output level in general-purpose mode
    input  wire logic               addr_bit_i,        // External address bit for this pin
    input  wire logic               addr_drive_i,      // Address lines are to be driven
    input  wire logic               clk_sel_i,         // Clock monitor chosen over address
    input  wire logic               clk_bit_i,         // Synchronised monitored clock
    output pbm_pkg::pbm_drive_type  drive_o            // Next pin level and enable
);

    wire use_clk = HAS_CLK && clk_sel_i;

    assign drive_o.out = gpio_en_i ? data_i    : (use_clk ? clk_bit_i : addr_bit_i);
    assign drive_o.oe  = gpio_en_i ? dir_out_i : (use_clk ? 1'b1 : addr_drive_i);

endmodule

`default_nettype wire

// ### hdl/pbm_port_b_mux.sv
// Port B pin function multiplexer: general-purpose, upper address and clock monitor.
// Assumes the memory interface logic shares clk_i; pins, straps and monitored
// clocks arrive asynchronously and are synchronised here.
//
// Our own choices: the register offsets and the address-and-strobe port.
`default_nettype none

module pbm_port_b_mux (
    input  wire logic                  clk_i,          // 25 MHz clock
    input  wire logic                  reset_n_i,      // Asynchronous reset, active low
    input  wire logic [2:0]            addr_i,         // Register address
    input  wire logic [7:0]            wdata_i,        // Register write data
    input  wire logic                  wr_i,           // Write strobe
    input  wire logic                  rd_i,           // Read strobe
    output logic      [7:0]            rdata_o,        // Read data, cycle after strobe
    input  wire pbm_pkg::pbm_strap_type strap_i,       // Boot straps from pins
    input  wire logic                  bus_active_i,   // External bus access in progress
    input  wire logic [7:0]            ext_addr_i,     // External address bits 23 to 16
    input  wire logic [3:0]            mon_clk_i,      // Divider input, system, second system, oscillator
    input  wire logic [7:0]            pin_in_i,       // Pin input levels
    output logic      [7:0]            pin_out_o,      // Pin output levels
    output logic      [7:0]            pin_oe_o,       // Pin output enables, high drives
    output logic      [7:0]            pullup_en_o     // Pull-up enables
);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [3:0] clk_meta;
    logic [3:0] clk_sync;
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta   <= 8'h00;
            pin_sync   <= 8'h00;
            clk_meta   <= 4'h0;
            clk_sync   <= 4'h0;
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
        end else begin
            pin_meta   <= pin_in_i;
            pin_sync   <= pin_meta;
            clk_meta   <= mon_clk_i;
            clk_sync   <= clk_meta;
            strap_meta <= strap_i;
            strap_sync <= strap_meta;
        end
    end

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    logic [7:0] data_out;
    logic [7:0] direction;
    logic [7:0] periph_en;
    logic [7:0] pullup_en;
    logic [3:0] clk_out_sel;
    logic       bus_keep;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic       addr_start;

    wire wr_data   = wr_i && (addr_i == pbm_pkg::REG_DATA_OUT);
    wire wr_dir    = wr_i && (addr_i == pbm_pkg::REG_DIRECTION);
    wire wr_periph = wr_i && (addr_i == pbm_pkg::REG_PERIPH_EN);
    wire wr_pullup = wr_i && (addr_i == pbm_pkg::REG_PULLUP_EN);
    wire wr_clksel = wr_i && (addr_i == pbm_pkg::REG_CLK_OUT_SEL);
    wire wr_busctl = wr_i && (addr_i == pbm_pkg::REG_BUS_CTRL);

    // Secured flash keeps the memory-mode strap from exposing the address bus.
    wire pbm_pkg::pbm_strap_type straps = strap_sync;
    wire addr_pick = straps.external_boot_select
                   | (straps.memory_if_mode_select & ~straps.flash_secure);
    wire strap_take = !strap_done && (strap_cnt == pbm_pkg::STRAP_WAIT);

    logic [7:0] next_rdata;
    always_comb begin
        case (addr_i)
            pbm_pkg::REG_DATA_OUT:    next_rdata = data_out;
            pbm_pkg::REG_DIRECTION:   next_rdata = direction;
            pbm_pkg::REG_PERIPH_EN:   next_rdata = periph_en;
            pbm_pkg::REG_PULLUP_EN:   next_rdata = pullup_en;
            pbm_pkg::REG_CLK_OUT_SEL: next_rdata = {clk_out_sel, 4'h0};
            pbm_pkg::REG_BUS_CTRL:    next_rdata = {7'h00, bus_keep};
            pbm_pkg::REG_PIN_LEVEL:   next_rdata = pin_sync;
            pbm_pkg::REG_STARTUP:     next_rdata = {6'h00, addr_start, strap_done};
            default:                  next_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_out    <= pbm_pkg::RST_DATA_OUT;
            direction   <= pbm_pkg::RST_DIRECTION;
            pullup_en   <= pbm_pkg::RST_PULLUP_EN;
            clk_out_sel <= pbm_pkg::RST_CLK_OUT_SEL;
            bus_keep    <= pbm_pkg::RST_BUS_KEEP;
            rdata_o     <= 8'h00;
        end else begin
            if (wr_data)   data_out    <= wdata_i;
            if (wr_dir)    direction   <= wdata_i;
            if (wr_pullup) pullup_en   <= wdata_i;
            if (wr_clksel) clk_out_sel <= wdata_i[7:4];
            if (wr_busctl) bus_keep    <= wdata_i[pbm_pkg::BUS_KEEP_BIT];
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

    // The straps are caught once, after the synchronisers have filled;
    // a software write in that same cycle still wins.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            periph_en  <= pbm_pkg::RST_PERIPH_EN;
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
            addr_start <= 1'b0;
        end else begin
            if (!strap_done) strap_cnt <= strap_cnt + 2'h1;
            if (strap_take) begin
                strap_done <= 1'b1;
                addr_start <= addr_pick;
            end
            if (wr_periph) begin
                periph_en <= wdata_i;
            end else if (strap_take) begin
                periph_en[3:0] <= {4{~addr_pick}};
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------------
    // The keep bit trades idle bus power for defined levels: with it clear,
    // the upper address lines float between external accesses.
    wire       addr_drive = bus_active_i | bus_keep;
    wire [7:0] clk_sel_all = {clk_out_sel, 4'h0};
    wire [7:0] clk_bit_all = {clk_sync, 4'h0};
    pbm_pkg::pbm_drive_type next_drive [8];
    wire [7:0]              next_pin_out;
    wire [7:0]              next_pin_oe;

    for (genvar i = 0; i < 8; i++) begin : g_pin
        pbm_pin_cell #(
            .HAS_CLK (i >= pbm_pkg::CLK_PIN_LO)
        ) u_cell (
            .gpio_en_i    (periph_en[i]),
            .dir_out_i    (direction[i]),
            .data_i       (data_out[i]),
            .addr_bit_i   (ext_addr_i[i]),
            .addr_drive_i (addr_drive),
            .clk_sel_i    (clk_sel_all[i]),
            .clk_bit_i    (clk_bit_all[i]),
            .drive_o      (next_drive[i])
        );

        assign next_pin_out[i] = next_drive[i].out;
        assign next_pin_oe[i]  = next_drive[i].oe;
    end

    // Every pin output is registered, so a function switch never glitches a pin
    // while the select and enable bits settle.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_out_o   <= 8'h00;
            pin_oe_o    <= 8'h00;
            pullup_en_o <= pbm_pkg::RST_PULLUP_EN;
        end else begin
            pin_out_o   <= next_pin_out;
            pin_oe_o    <= next_pin_oe;
            pullup_en_o <= pullup_en;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    wire [7:0] addr_mask = ~periph_en & ~clk_sel_all;
    wire [7:0] clk_mask  = ~periph_en &  clk_sel_all;

    sequence periph_write_s;
        wr_i && (addr_i == pbm_pkg::REG_PERIPH_EN);
    endsequence

    gpio_dir_a: assert property (
        ((pin_oe_o ^ $past(direction)) & $past(periph_en)) == 8'h00)
        else $error("GPIO pin enable does not follow direction");

    idle_tristate_a: assert property (
        $past(!bus_active_i && !bus_keep) |-> (pin_oe_o & $past(addr_mask)) == 8'h00)
        else $error("Address pin driven on idle bus without keep");

    keep_drive_a: assert property (
        $past(bus_keep) |-> (pin_oe_o & $past(addr_mask)) == $past(addr_mask))
        else $error("Address pin not driven with keep set");

    strap_pick_a: assert property (
        $rose(strap_done) && !$past(wr_i) |-> periph_en[3:0] == {4{~$past(addr_pick)}})
        else $error("Startup function of low pins wrong");

    periph_write_a: assert property (
        periph_write_s |=> periph_en == $past(wdata_i))
        else $error("Peripheral enable write not applied");

    pullup_path_a: assert property (
        wr_i && (addr_i == pbm_pkg::REG_PULLUP_EN) |-> ##2 pullup_en_o == $past(wdata_i, 2))
        else $error("Pull-up enables do not follow write");

    high_pins_gpio_a: assert property (
        $rose(strap_done) && !$past(wr_i) |-> periph_en[7:4] == 4'hf)
        else $error("High pins left general-purpose control at startup");

    clk_monitor_a: assert property (
        ((pin_out_o ^ {$past(clk_sync), 4'h0}) & $past(clk_mask)) == 8'h00)
        else $error("Clock monitor pin does not show its clock");

    handoff_a: assert property (
        periph_write_s ##1 !wr_i |=>
            ((pin_oe_o ^ {8{$past(bus_active_i || bus_keep)}}) & $past(addr_mask)) == 8'h00)
        else $error("Pin not handed to its address function after enable write");

    clk_select_a: assert property (
        $past(clk_mask) != 8'h00 |-> (pin_oe_o & $past(clk_mask)) == $past(clk_mask))
        else $error("Clock monitor pin not driven");

    addr_bit_a: assert property (
        ((pin_out_o ^ $past(ext_addr_i)) & $past(addr_mask)) == 8'h00)
        else $error("Address pin does not carry its address bit");

    // ------------------------------------------------------------------
    // Startup, readback and drive checks
    // ------------------------------------------------------------------
    // These watch register state and, in gpio_out_a, addr_busy_a, pullup_follow_a and low_pins_addr_a, the pins too,
    // so a broken pin cell can show up here as well as in the pin checks above.
    sequence strap_window_s;
        !strap_done && (strap_cnt == pbm_pkg::STRAP_WAIT);
    endsequence

    sequence bus_busy_s;
        bus_active_i || bus_keep;
    endsequence

    strap_wait_a: assert property (
        !strap_done |-> (strap_cnt <= pbm_pkg::STRAP_WAIT))
        else $error("Strap wait counter ran past its end");

    strap_capture_a: assert property (
        strap_window_s |=> strap_done && (addr_start == $past(addr_pick)))
        else $error("Straps not captured at the end of the wait");

    strap_hold_a: assert property (
        strap_done |=> strap_done && $stable(addr_start))
        else $error("Startup record changed after capture");

    gpio_out_a: assert property (
        ((pin_out_o ^ $past(data_out)) & $past(periph_en)) == 8'h00)
        else $error("GPIO pin level does not follow data register");

    pin_read_a: assert property (
        $past(rd_i && (addr_i == pbm_pkg::REG_PIN_LEVEL)) |-> rdata_o == $past(pin_sync))
        else $error("Pin level read does not return synchronised pins");

    addr_busy_a: assert property (
        bus_busy_s |=> (pin_oe_o & $past(addr_mask)) == $past(addr_mask))
        else $error("Address pin not driven during bus access");

    keep_write_a: assert property (
        wr_busctl |=> bus_keep == $past(wdata_i[pbm_pkg::BUS_KEEP_BIT]))
        else $error("Drive-keep bit write not applied");

    periph_read_a: assert property (
        $past(rd_i && (addr_i == pbm_pkg::REG_PERIPH_EN)) |-> rdata_o == $past(periph_en))
        else $error("Peripheral enable read does not return the register");

    pullup_follow_a: assert property (
        pullup_en_o == $past(pullup_en))
        else $error("Pull-up enable pins lag the register by more than a cycle");

    low_pins_addr_a: assert property (
        ((pin_out_o ^ $past(ext_addr_i)) & ~$past(periph_en) & 8'h0f) == 8'h00)
        else $error("Low pin in peripheral function not carrying its address bit");

endmodule

`default_nettype wire

// ### shared/pbm_pkg.sv
// Constants and carrier types for the port B pin function multiplexer.
// Assumes a single 25 MHz clock domain shared by every user of the package.
`default_nettype none

package pbm_pkg;

    // ------------------------------------------------------------------
    // Widths and register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W         = 3;
    localparam int         DATA_W         = 8;
    localparam logic [2:0] REG_DATA_OUT   = 3'h0;
    localparam logic [2:0] REG_DIRECTION  = 3'h1;
    localparam logic [2:0] REG_PERIPH_EN  = 3'h2;
    localparam logic [2:0] REG_PULLUP_EN  = 3'h3;
    localparam logic [2:0] REG_CLK_OUT_SEL = 3'h4;
    localparam logic [2:0] REG_BUS_CTRL   = 3'h5;
    localparam logic [2:0] REG_PIN_LEVEL  = 3'h6;
    localparam logic [2:0] REG_STARTUP    = 3'h7;

    // ------------------------------------------------------------------
    // Field positions and values after reset
    // ------------------------------------------------------------------
    localparam int         BUS_KEEP_BIT   = 0;
    localparam int         CLK_PIN_LO     = 4;
    localparam logic [7:0] RST_DATA_OUT   = 8'h00;
    localparam logic [7:0] RST_DIRECTION  = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN  = 8'hff;
    localparam logic [7:0] RST_PULLUP_EN  = 8'hff;
    localparam logic [3:0] RST_CLK_OUT_SEL = 4'h0;
    localparam logic       RST_BUS_KEEP   = 1'b0;

    // Cycles after reset release before the synchronised straps are valid.
    localparam logic [1:0] STRAP_WAIT     = 2'h2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } pbm_drive_type;

    typedef struct packed {
        logic external_boot_select;
        logic memory_if_mode_select;
        logic flash_secure;
    } pbm_strap_type;

endpackage

`default_nettype wire

// ### verification/pbm_mem_model.sv
// Far side of port B: external memory and board wiring on the eight pins.
// Assumes pin levels are resolved here and fed back to the multiplexer inputs.
`default_nettype none

module pbm_mem_model (
    input  wire logic [7:0] pin_out_i,    // Levels driven by the device
    input  wire logic [7:0] pin_oe_i,     // Device output enables
    input  wire logic [7:0] pullup_en_i,  // Device pull-up enables
    input  wire logic [7:0] ext_level_i,  // Levels the board drives
    input  wire logic [7:0] ext_en_i,     // Board drives the pin
    output logic      [7:0] pin_in_o,     // Resolved pin levels
    output logic      [7:0] addr_seen_o   // Upper address seen by memory
);
    timeunit 1ns;
    timeprecision 1ps;

    // A pin that nobody drives and nothing pulls up shows the inverse of the
    // device's current output level, so a stale value can never pass for a real one.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_i[i]) begin
                pin_in_o[i] = pin_out_i[i];
            end else if (ext_en_i[i]) begin
                pin_in_o[i] = ext_level_i[i];
            end else if (pullup_en_i[i]) begin
                pin_in_o[i] = 1'b1;
            end else begin
                pin_in_o[i] = ~pin_out_i[i];
            end
        end
    end

    assign addr_seen_o = pin_in_o;
endmodule

`default_nettype wire

// ### verification/test_port_b_pin_function_mux.sv
// Self-checking bench for the port B pin function multiplexer.
// Assumes the register bus and pins of pbm_port_b_mux and the memory model beside it.
`default_nettype none

module test_port_b_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_i = 1'b0;
    logic                   reset_n_i = 1'b0;
    logic [2:0]             addr_i = 3'h0;
    logic [7:0]             wdata_i = 8'h00;
    logic                   wr_i = 1'b0;
    logic                   rd_i = 1'b0;
    logic [7:0]             rdata_o;
    pbm_pkg::pbm_strap_type strap_i = 3'h4;
    logic                   bus_active_i = 1'b0;
    logic [7:0]             ext_addr_i = 8'h00;
    logic [3:0]             mon_clk_i = 4'h0;
    logic [7:0]             pin_in_i;
    logic [7:0]             pin_out_o;
    logic [7:0]             pin_oe_o;
    logic [7:0]             pullup_en_o;
    logic [7:0]             ext_level = 8'h00;
    logic [7:0]             ext_en = 8'hff;
    logic [7:0]             d, dr, a, p;
    logic                   b;
    int                     err_total = 0;
    int                     comparisons = 0;
    int                     r;

    always #20 clk_i = ~clk_i;

    pbm_port_b_mux dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .strap_i(strap_i), .bus_active_i(bus_active_i),
        .ext_addr_i(ext_addr_i), .mon_clk_i(mon_clk_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o));

    pbm_mem_model mem_u (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pullup_en_i(pullup_en_o),
        .ext_level_i(ext_level), .ext_en_i(ext_en), .pin_in_o(pin_in_i), .addr_seen_o());

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic wr(input logic [2:0] ad, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= ad;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] ad, input logic [7:0] exp, input string name);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= ad;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(name, rdata_o, exp);
    endtask

    // An undriven pin reads its pull-up, or else the inverse of the data bit.
    function automatic logic [7:0] level_exp(input logic [7:0] dir, data, ext, en, pu);
        return (dir & data) | (~dir & en & ext) | (~dir & ~en & pu) | (~dir & ~en & ~pu & ~data);
    endfunction

    function automatic logic pick_exp(input logic [2:0] s);
        return s[2] | (s[1] & ~s[0]);
    endfunction

    task automatic restart(input logic [2:0] s);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        strap_i <= s;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        settle(4);
    endtask

    initial begin
        #(40 * 5000);
        err_total++;
        complete_run();
    end

    initial begin
        r = $urandom(32'h9d31875d);
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        settle(4);
        chk("oe_after_reset", pin_oe_o, 8'h00);
        chk("pullup_reset", pullup_en_o, 8'hff);
        rd_chk(pbm_pkg::REG_STARTUP, 8'h03, "startup");
        rd_chk(pbm_pkg::REG_PERIPH_EN, 8'hf0, "periph_start");
        rd_chk(pbm_pkg::REG_CLK_OUT_SEL, 8'h00, "clk_sel_reset");
        rd_chk(pbm_pkg::REG_BUS_CTRL, 8'h00, "bus_ctrl_reset");
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            wr(pbm_pkg::REG_PERIPH_EN, a);
            rd_chk(pbm_pkg::REG_PERIPH_EN, a, "periph_override");
        end
        wr(pbm_pkg::REG_PERIPH_EN, 8'hff);
        // General-purpose pins with random direction, data and board levels.
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            dr = (i == 0) ? 8'hff : 8'($urandom);
            p = (i == 0) ? 8'h00 : 8'($urandom);
            ext_level <= 8'($urandom);
            ext_en <= 8'($urandom);
            wr(pbm_pkg::REG_DATA_OUT, d);
            wr(pbm_pkg::REG_DIRECTION, dr);
            wr(pbm_pkg::REG_PULLUP_EN, p);
            settle(2);
            chk("gpio_oe", pin_oe_o, dr);
            chk("gpio_out", pin_out_o, d);
            chk("pullup", pullup_en_o, p);
            settle(3);
            rd_chk(pbm_pkg::REG_PIN_LEVEL, level_exp(dr, d, ext_level, ext_en, p), "pin_level");
        end
        // Address function with the keep bit clear: enables follow bus activity.
        wr(pbm_pkg::REG_PERIPH_EN, 8'h00);
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            b = (i < 2) ? i[0] : 1'($urandom);
            @(posedge clk_i);
            ext_addr_i <= a;
            bus_active_i <= b;
            settle(2);
            chk("addr_out", pin_out_o, a);
            chk("addr_oe", pin_oe_o, {8{b}});
        end
        @(posedge clk_i);
        bus_active_i <= 1'b0;
        wr(pbm_pkg::REG_BUS_CTRL, 8'h01);
        settle(2);
        chk("keep_oe", pin_oe_o, 8'hff);
        // Clock monitor on pins 4 to 7, one clock at a time.
        wr(pbm_pkg::REG_CLK_OUT_SEL, 8'hf0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            mon_clk_i <= 4'h1 << i;
            settle(4);
            chk("mon_out", {4'h0, pin_out_o[7:4]}, {4'h0, 4'h1 << i});
            chk("mon_low_addr", {4'h0, pin_out_o[3:0]}, {4'h0, a[3:0]});
        end
        @(posedge clk_i);
        mon_clk_i <= 4'hf;
        ext_addr_i <= 8'h00;
        wr(pbm_pkg::REG_CLK_OUT_SEL, 8'ha0);
        settle(4);
        chk("mixed_sel", pin_out_o, 8'ha0);
        wr(pbm_pkg::REG_STARTUP, 8'h00);
        wr(pbm_pkg::REG_PIN_LEVEL, 8'h00);
        rd_chk(pbm_pkg::REG_STARTUP, 8'h03, "startup_ro");
        rd_chk(pbm_pkg::REG_PIN_LEVEL, 8'ha0, "pin_level_ro");
        // Every strap combination, each through a reset in mid-run.
        for (int s = 0; s < 8; s++) begin
            restart(3'(s));
            chk("oe_restart", pin_oe_o, 8'h00);
            rd_chk(pbm_pkg::REG_STARTUP, {6'h00, pick_exp(3'(s)), 1'b1}, "startup_strap");
            rd_chk(pbm_pkg::REG_PERIPH_EN, {4'hf, {4{~pick_exp(3'(s))}}}, "periph_strap");
        end
        complete_run();
    end
endmodule

`default_nettype wire
